// ### logic/pco_clock_out.sv
// Programmable clock output: crystal divider, HF synthesiser and sequencer
`timescale 1ns/1ns
module pco_clock_out #(
	parameter logic [15:0] CYC_ON_32K = pco_pkg::CYC_ON_32K,
	parameter logic [15:0] CYC_ON_HF = pco_pkg::CYC_ON_HF,
	parameter logic [15:0] CYC_OFF = pco_pkg::CYC_OFF,
	parameter logic [15:0] CYC_OLD_XTAL = pco_pkg::CYC_OLD_XTAL,
	parameter logic [15:0] CYC_LOW_TO_HF = pco_pkg::CYC_LOW_TO_HF,
	parameter logic [15:0] CYC_OLD_HF = pco_pkg::CYC_OLD_HF,
	parameter logic [15:0] CYC_LOW_TO_XTAL = pco_pkg::CYC_LOW_TO_XTAL
) (
	input wire logic I_CLK,
	input wire logic I_RSTN,
	input wire logic I_XTAL_IN,
	input wire logic I_EVENT_INPUT_PIN,
	input wire logic I_BACKUP_SUPPLY,
	input wire logic I_STOP_BIT,
	input wire logic I_SEC_WRITE,
	input wire logic I_COMP_ADD,
	input wire logic I_COMP_SKIP,
	input wire logic I_IRQ_CLOCK_OUT_FLAG,
	input wire logic [pco_pkg::ADDR_W-1:0] I_ADDR,
	input wire logic [pco_pkg::DATA_W-1:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	output logic [pco_pkg::DATA_W-1:0] O_RDATA,
	output logic O_CLOCK_OUT_PIN
);

	// Configuration mirror, written by software
	pco_pkg::pco_cfg_t cfg_reg;
	// Synchroniser chains for the asynchronous pins
	logic xtal_s1_reg;
	logic xtal_s2_reg;
	logic xtal_prev_reg;
	logic evt_s1_reg;
	logic evt_s2_reg;
	logic evt_prev_reg;
	logic bkp_s1_reg;
	logic bkp_s2_reg;
	// Crystal prescaler, counts 32768 Hz edges
	logic [pco_pkg::PRESC_W-1:0] presc_reg;
	// HF phase accumulator and its square wave
	logic [pco_pkg::ACC_W-1:0] acc_reg;
	logic hf_wave_reg;
	// Sequencer
	pco_pkg::pco_state_t state_reg;
	pco_pkg::pco_state_t state_next;
	logic [pco_pkg::CNT_W-1:0] cnt_reg;
	logic [pco_pkg::CNT_W-1:0] cnt_next;
	logic active_os_reg;
	logic active_os_next;
	logic pin_next;
	// Derived terms, combinational except xtal_wave_prev_reg
	logic xtal_tick;
	logic evt_rise;
	logic presc_clear;
	logic xtal_wave;
	logic xtal_wave_prev_reg;
	logic want_on;
	logic [pco_pkg::ACC_W-1:0] hf_step;

	// Reduce the HF increment modulo the system clock rate
	function automatic logic [pco_pkg::ACC_W-1:0] step_of(
		input logic [12:0] div
	);
		logic [pco_pkg::ACC_W-1:0] s;
		s = pco_pkg::ACC_W'((32'(div) + 32'h1) * pco_pkg::HF_STEP_HZ);
		for (int i = 0; i < 4; i++) begin
			if (s >= pco_pkg::ACC_W'(pco_pkg::CLK_HZ)) begin
				s = s - pco_pkg::ACC_W'(pco_pkg::CLK_HZ);
			end
		end
		return s;
	endfunction : step_of

	// Turn-on delay of the source that is about to start
	function automatic logic [pco_pkg::CNT_W-1:0] on_delay(
		input logic os,
		input logic [1:0] fsel
	);
		if (os) begin
			return CYC_ON_HF;
		end else if (fsel == pco_pkg::XSEL_32K) begin
			return CYC_ON_32K;
		end
		return 16'h0001;
	endfunction : on_delay

	// Register writes; configuration steers the whole block
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			// [R8] Delivery configuration
			cfg_reg.osc_source_select <= pco_pkg::RST_OSC_SRC;
			cfg_reg.xtal_freq_select <= pco_pkg::RST_XTAL_SEL;
			cfg_reg.normal_out_disable <= pco_pkg::RST_NOUT_DIS;
			cfg_reg.event_sync_enable <= pco_pkg::RST_EVT_SYNC;
			cfg_reg.hf_divider_value <= pco_pkg::RST_HF_DIV;
		end else if (I_WR) begin
			case (I_ADDR)
				// Source, crystal select, disable, event sync
				pco_pkg::OFS_CFG: begin
					cfg_reg.osc_source_select <= I_WDATA[pco_pkg::POS_OSC_SRC];
					cfg_reg.xtal_freq_select <=
						I_WDATA[pco_pkg::POS_XTAL_SEL +: 2];
					cfg_reg.normal_out_disable <= I_WDATA[pco_pkg::POS_NOUT_DIS];
					cfg_reg.event_sync_enable <= I_WDATA[pco_pkg::POS_EVT_SYNC];
				end
				// Divider acts at once; host should disable first
				pco_pkg::OFS_HFDIV: begin
					cfg_reg.hf_divider_value <= I_WDATA[12:0];
				end
				// Status and unmapped writes are ignored
				default: begin
				end
			endcase
		end
	end

	// Read data, valid only in the cycle after the read strobe
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			O_RDATA <= '0;
		end else if (I_RD) begin
			case (I_ADDR)
				pco_pkg::OFS_CFG: begin
					O_RDATA <= {11'h000, cfg_reg.event_sync_enable,
						cfg_reg.normal_out_disable, cfg_reg.xtal_freq_select,
						cfg_reg.osc_source_select};
				end
				pco_pkg::OFS_HFDIV: begin
					O_RDATA <= {3'h0, cfg_reg.hf_divider_value};
				end
				// Live state: on, busy, active source, backup, pin
				pco_pkg::OFS_STATUS: begin
					O_RDATA <= {11'h000, O_CLOCK_OUT_PIN, bkp_s2_reg,
						active_os_reg,
						(state_reg != pco_pkg::ST_ON)
							&& (state_reg != pco_pkg::ST_OFF),
						state_reg == pco_pkg::ST_ON};
				end
				// Unmapped reads answer zero
				default: begin
					O_RDATA <= '0;
				end
			endcase
		end else begin
			O_RDATA <= '0;
		end
	end

	// Two-stage synchronisers; only stage two is read by logic
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			xtal_s1_reg <= 1'h0;
			xtal_s2_reg <= 1'h0;
			xtal_prev_reg <= 1'h0;
			evt_s1_reg <= 1'h0;
			evt_s2_reg <= 1'h0;
			evt_prev_reg <= 1'h0;
			bkp_s1_reg <= 1'h0;
			bkp_s2_reg <= 1'h0;
		end else begin
			xtal_s1_reg <= I_XTAL_IN;
			xtal_s2_reg <= xtal_s1_reg;
			xtal_prev_reg <= xtal_s2_reg;
			evt_s1_reg <= I_EVENT_INPUT_PIN;
			evt_s2_reg <= evt_s1_reg;
			evt_prev_reg <= evt_s2_reg;
			bkp_s1_reg <= I_BACKUP_SUPPLY;
			bkp_s2_reg <= bkp_s1_reg;
		end
	end

	// One pulse per crystal rising edge
	assign xtal_tick = xtal_s2_reg && !xtal_prev_reg;
	// Event input is inert while on backup power
	assign evt_rise = evt_s2_reg && !evt_prev_reg && !bkp_s2_reg;
	// [R11] Prescaler resynchronised
	assign presc_clear = I_SEC_WRITE
		|| (cfg_reg.event_sync_enable && evt_rise);

	// Crystal prescaler with compensation and stop
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			presc_reg <= '0;
		end else if (presc_clear) begin
			// [R11] Current period cut short
			presc_reg <= '0;
		end else if (I_STOP_BIT) begin
			// [R10] Divided outputs hold level
			presc_reg <= presc_reg;
		end else begin
			// [R3] Compensation pulses add or drop
			presc_reg <= presc_reg
				+ pco_pkg::PRESC_W'(xtal_tick)
				+ pco_pkg::PRESC_W'(I_COMP_ADD)
				- pco_pkg::PRESC_W'(I_COMP_SKIP && (xtal_tick || I_COMP_ADD));
		end
	end

	// Crystal mode waveform selection
	always_comb begin
		case (cfg_reg.xtal_freq_select)
			// [R3] Raw crystal, uncompensated
			pco_pkg::XSEL_32K: xtal_wave = xtal_s2_reg;
			// [R2] Divided taps
			pco_pkg::XSEL_1K: xtal_wave = presc_reg[pco_pkg::TAP_1K];
			pco_pkg::XSEL_64: xtal_wave = presc_reg[pco_pkg::TAP_64];
			pco_pkg::XSEL_1: xtal_wave = presc_reg[pco_pkg::TAP_1];
			default: xtal_wave = 1'h0;
		endcase
	end

	// Previous crystal waveform, for rising edge detection
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			xtal_wave_prev_reg <= 1'h0;
		end else begin
			xtal_wave_prev_reg <= xtal_wave;
		end
	end

	// [R5] HF step from divider value
	assign hf_step = step_of(cfg_reg.hf_divider_value);

	// HF synthesiser; steps above half the clock rate alias
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			acc_reg <= '0;
			hf_wave_reg <= 1'h0;
		end else begin
			// [R6] [R12] No compensation, no resync
			if (acc_reg + hf_step >= pco_pkg::ACC_W'(pco_pkg::CLK_HZ)) begin
				acc_reg <= acc_reg + hf_step - pco_pkg::ACC_W'(pco_pkg::CLK_HZ);
			end else begin
				acc_reg <= acc_reg + hf_step;
			end
			hf_wave_reg <= acc_reg >= pco_pkg::ACC_W'(pco_pkg::CLK_HZ / 2);
		end
	end

	// [R9] [R15] [R21] Enable from bit or flag
	assign want_on = !cfg_reg.normal_out_disable || I_IRQ_CLOCK_OUT_FLAG;

	// Sequencer: on/off delays and source changeover
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		active_os_next = active_os_reg;
		pin_next = 1'h0;
		case (state_reg)
			// Output held low until enabled
			pco_pkg::ST_OFF: begin
				if (want_on) begin
					// [R14] Start delay per source
					cnt_next = on_delay(cfg_reg.osc_source_select,
						cfg_reg.xtal_freq_select);
					active_os_next = cfg_reg.osc_source_select;
					state_next = pco_pkg::ST_ON_WAIT;
				end
			end
			// Waiting for the source to settle
			pco_pkg::ST_ON_WAIT: begin
				if (!want_on) begin
					state_next = pco_pkg::ST_OFF;
				end else if (cnt_reg <= 16'h0001) begin
					state_next = pco_pkg::ST_ON;
				end else begin
					cnt_next = cnt_reg - 16'h0001;
				end
			end
			// Running; [R1] [R4] source mux, [R19] select live
			pco_pkg::ST_ON: begin
				pin_next = active_os_reg ? hf_wave_reg : xtal_wave;
				if (!want_on) begin
					if (!active_os_reg
						&& cfg_reg.xtal_freq_select != pco_pkg::XSEL_32K) begin
						state_next = pco_pkg::ST_OFF_DIV;
					end else begin
						// [R14] Stop delay
						cnt_next = CYC_OFF;
						state_next = pco_pkg::ST_OFF_WAIT;
					end
				end else if (cfg_reg.osc_source_select != active_os_reg) begin
					// [R16] [R17] Old frequency kept first
					cnt_next = active_os_reg ? CYC_OLD_HF : CYC_OLD_XTAL;
					state_next = pco_pkg::ST_SW_OLD;
				end
			end
			// Old source runs out its stop delay
			pco_pkg::ST_OFF_WAIT: begin
				pin_next = active_os_reg ? hf_wave_reg : xtal_wave;
				if (cnt_reg <= 16'h0001) begin
					state_next = pco_pkg::ST_OFF;
				end else begin
					cnt_next = cnt_reg - 16'h0001;
				end
			end
			// [R13] Finish current period, then low
			pco_pkg::ST_OFF_DIV: begin
				pin_next = xtal_wave;
				if (!xtal_wave || I_STOP_BIT) begin
					pin_next = 1'h0;
					state_next = pco_pkg::ST_OFF;
				end
			end
			// Old frequency continues briefly
			pco_pkg::ST_SW_OLD: begin
				pin_next = active_os_reg ? hf_wave_reg : xtal_wave;
				if (!want_on) begin
					state_next = pco_pkg::ST_OFF;
				end else if (cnt_reg <= 16'h0001) begin
					// [R16] [R17] Low gap length
					active_os_next = cfg_reg.osc_source_select;
					cnt_next = cfg_reg.osc_source_select ? CYC_LOW_TO_HF
						: CYC_LOW_TO_XTAL;
					state_next = pco_pkg::ST_SW_LOW;
				end else begin
					cnt_next = cnt_reg - 16'h0001;
				end
			end
			// Pin low between old and new source
			pco_pkg::ST_SW_LOW: begin
				if (!want_on) begin
					state_next = pco_pkg::ST_OFF;
				end else if (cnt_reg <= 16'h0001) begin
					state_next = active_os_reg ? pco_pkg::ST_ON
						: pco_pkg::ST_SW_EDGE;
				end else begin
					cnt_next = cnt_reg - 16'h0001;
				end
			end
			// [R17] Low until new rising edge
			pco_pkg::ST_SW_EDGE: begin
				if (!want_on) begin
					state_next = pco_pkg::ST_OFF;
				end else if (xtal_wave && !xtal_wave_prev_reg) begin
					pin_next = 1'h1;
					state_next = pco_pkg::ST_ON;
				end
			end
			default: begin
				state_next = pco_pkg::ST_OFF;
			end
		endcase
	end

	// Sequencer state registers
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			state_reg <= pco_pkg::ST_OFF;
			cnt_reg <= '0;
			active_os_reg <= pco_pkg::RST_OSC_SRC;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			active_os_reg <= active_os_next;
		end
	end

	// Output pin register; backup power overrides everything
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			O_CLOCK_OUT_PIN <= 1'h0;
		end else if (bkp_s2_reg) begin
			// [R7] Backup forces low
			O_CLOCK_OUT_PIN <= 1'h0;
		end else begin
			O_CLOCK_OUT_PIN <= pin_next;
		end
	end

endmodule : pco_clock_out

// ### inc/pco_pkg.sv
// Package of constants and types for the programmable clock output block
// Behaviour
// [R1] Source bit 0 selects crystal mode
// [R2] Crystal select: 32768, 1024, 64, 1 Hz
// [R3] 32768 Hz raw; divided outputs get compensation
// [R4] Source bit 1 selects high-frequency mode
// [R5] HF frequency is (divider+1) times 8192 Hz; here aliases above half the clock rate
// [R6] HF output gets no compensation pulses
// [R7] Backup supply forces output pin low
// [R8] Reset configuration gives 32768 Hz enabled
// [R9] Disable bit forces low unless flag set
// [R10] Stop halts divided outputs, holds level
// [R11] Seconds write or event resets prescaler
// [R12] HF periods ignore seconds write, events
// [R13] Divided off waits up to one period
// [R14] Turn-on and turn-off delays per source
// [R15] Interrupt flag switches like disable bit
// [R16] Crystal to HF: old, low, new
// [R17] HF to crystal: old, low, edge
// [R18] Host changes source alone, not frequency
// [R19] Crystal select change acts immediately
// [R20] Host disables before divider change
// [R21] Flag clear while disabled drives low
package pco_pkg;
	// Register bus widths and offsets
	localparam int ADDR_W = 2;
	localparam int DATA_W = 16;
	localparam logic [1:0] OFS_CFG = 2'h0;
	localparam logic [1:0] OFS_HFDIV = 2'h1;
	localparam logic [1:0] OFS_STATUS = 2'h2;
	// Field positions in the configuration register
	localparam int POS_OSC_SRC = 0;
	localparam int POS_XTAL_SEL = 1;
	localparam int POS_NOUT_DIS = 3;
	localparam int POS_EVT_SYNC = 4;
	// Reset values (delivery configuration)
	localparam logic RST_OSC_SRC = 1'h0;
	localparam logic [1:0] RST_XTAL_SEL = 2'h0;
	localparam logic RST_NOUT_DIS = 1'h0;
	localparam logic RST_EVT_SYNC = 1'h0;
	localparam logic [12:0] RST_HF_DIV = 13'h0000;
	// Crystal select codes
	localparam logic [1:0] XSEL_32K = 2'h0;
	localparam logic [1:0] XSEL_1K = 2'h1;
	localparam logic [1:0] XSEL_64 = 2'h2;
	localparam logic [1:0] XSEL_1 = 2'h3;
	// Prescaler tap positions for the divided frequencies
	localparam int PRESC_W = 15;
	localparam int TAP_1K = 4;
	localparam int TAP_64 = 8;
	localparam int TAP_1 = 14;
	// System clock and HF synthesis
	localparam int CLK_NS = 50;
	localparam int CLK_HZ = 20_000_000;
	localparam int HF_STEP_HZ = 8192;
	localparam int ACC_W = 27;
	// Transition times in ns
	localparam int T_ON_32K_NS = 600_000;
	localparam int T_ON_HF_NS = 2_500_000;
	localparam int T_OFF_NS = 400_000;
	localparam int T_OLD_XTAL_NS = 350_000;
	localparam int T_LOW_TO_HF_NS = 2_300_000;
	localparam int T_OLD_HF_NS = 300_000;
	localparam int T_LOW_TO_XTAL_NS = 650_000;
	// Derived cycle counts, rounded up to whole cycles
	localparam int CNT_W = 16;
	localparam logic [15:0] CYC_ON_32K = 16'((T_ON_32K_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [15:0] CYC_ON_HF = 16'((T_ON_HF_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [15:0] CYC_OFF = 16'((T_OFF_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [15:0] CYC_OLD_XTAL =
		16'((T_OLD_XTAL_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [15:0] CYC_LOW_TO_HF =
		16'((T_LOW_TO_HF_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [15:0] CYC_OLD_HF = 16'((T_OLD_HF_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [15:0] CYC_LOW_TO_XTAL =
		16'((T_LOW_TO_XTAL_NS + CLK_NS - 1) / CLK_NS);
	// Output configuration carried as one bundle
	typedef struct packed {
		logic osc_source_select;
		logic [1:0] xtal_freq_select;
		logic normal_out_disable;
		logic event_sync_enable;
		logic [12:0] hf_divider_value;
	} pco_cfg_t;
	// Output sequencer states
	typedef enum logic [2:0] {
		ST_OFF, ST_ON_WAIT, ST_ON, ST_OFF_WAIT, ST_OFF_DIV,
		ST_SW_OLD, ST_SW_LOW, ST_SW_EDGE
	} pco_state_t;
endpackage : pco_pkg

// ### test/pco_checker.sv
// Assertion checker bound to the clock output block ports
`timescale 1ns/1ns
module pco_checker #(
	parameter logic [15:0] CYC_ON_32K = 16'h0010,
	parameter int LIM = 400
) (
	input wire logic I_CLK,
	input wire logic I_RSTN,
	input wire logic I_EVENT_INPUT_PIN,
	input wire logic I_BACKUP_SUPPLY,
	input wire logic I_STOP_BIT,
	input wire logic I_SEC_WRITE,
	input wire logic I_IRQ_CLOCK_OUT_FLAG,
	input wire logic [1:0] I_ADDR,
	input wire logic [15:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	input wire logic [15:0] O_RDATA,
	input wire logic O_CLOCK_OUT_PIN
);
	logic [4:0] cfg_reg; // Shadow of the configuration word
	int off_reg; // Cycles spent disabled with the flag clear
	logic [15:0] up_reg; // Cycles since reset release
	default clocking @(posedge I_CLK); endclocking
	default disable iff (!I_RSTN);
	// Shadow follows every configuration write
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) cfg_reg <= 5'h00;
		else if (I_WR && I_ADDR == 2'h0) cfg_reg <= I_WDATA[4:0];
	end
	// Saturating counters keep the helper logic bounded
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) off_reg <= 0;
		else if (!cfg_reg[3] || I_IRQ_CLOCK_OUT_FLAG) off_reg <= 0;
		else if (off_reg < LIM) off_reg <= off_reg + 1;
	end
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) up_reg <= 16'h0000;
		else if (up_reg != 16'hffff) up_reg <= up_reg + 16'h0001;
	end
	// Divided wave frozen: nothing may disturb it
	sequence s_quiet;
		I_STOP_BIT && !I_SEC_WRITE && !I_WR && !I_BACKUP_SUPPLY &&
			!I_EVENT_INPUT_PIN && !cfg_reg[0] && cfg_reg[2:1] != 2'h0;
	endsequence
	// Seconds write while the 1024 Hz wave runs
	sequence s_clr;
		!cfg_reg[0] && cfg_reg[2:1] == 2'h1 && !I_STOP_BIT && I_SEC_WRITE;
	endsequence
	a_backup_pin_low: assert property (I_BACKUP_SUPPLY [*4] |->
		!O_CLOCK_OUT_PIN) else $error("pin high in backup");
	a_rdata_idle_zero: assert property (!$past(I_RD) |->
		O_RDATA == 16'h0000) else $error("read data outside slot");
	a_unmapped_read: assert property ($past(I_RD) && $past(I_ADDR) == 2'h3
		|-> O_RDATA == 16'h0000) else $error("unmapped read not zero");
	a_cfg_read_back: assert property ($past(I_RD) &&
		$past(I_ADDR) == 2'h0 |-> O_RDATA == {11'h000, $past(cfg_reg)})
		else $error("config readback wrong");
	a_disable_low: assert property (off_reg >= LIM |->
		!O_CLOCK_OUT_PIN) else $error("pin runs while disabled");
	a_start_delay: assert property (up_reg < CYC_ON_32K |->
		!O_CLOCK_OUT_PIN) else $error("pin started too early");
	a_stop_hold_level: assert property (s_quiet [*6] |->
		$stable(O_CLOCK_OUT_PIN)) else $error("stopped wave moved");
	a_sec_clear_period: assert property (s_clr |-> ##4
		!O_CLOCK_OUT_PIN [*8]) else $error("period not restarted");
endmodule : pco_checker
bind pco_clock_out pco_checker #(.CYC_ON_32K(CYC_ON_32K)) i_chk (.I_CLK,
	.I_RSTN, .I_EVENT_INPUT_PIN, .I_BACKUP_SUPPLY, .I_STOP_BIT, .I_SEC_WRITE,
	.I_IRQ_CLOCK_OUT_FLAG, .I_ADDR, .I_WDATA, .I_WR, .I_RD, .O_RDATA,
	.O_CLOCK_OUT_PIN);

// ### test/pco_partner.sv
// Far side model: crystal source and a consumer counting clock edges
`timescale 1ns/1ns
module pco_partner #(
	parameter int XT_HALF_NS = 200
) (
	input wire logic i_clk,
	input wire logic i_pin,
	output logic o_xtal,
	output int o_rises
);
	logic last_reg = 1'b0; // Pin level at the previous edge
	initial o_xtal = 1'b0;
	initial o_rises = 0;
	// Fast stand-in crystal, toggling on falling clock edges to avoid races
	always #(XT_HALF_NS) o_xtal = ~o_xtal;
	// Consumer counts only clean low-to-high steps
	always @(posedge i_clk) begin
		if (i_pin === 1'b1 && last_reg === 1'b0) o_rises <= o_rises + 1;
		last_reg <= i_pin;
	end
endmodule : pco_partner

// ### test/programmable_clock_output_tb.sv
// Self-checking bench for the programmable clock output block
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
	num_errors++; $display("unexpected %s: expected %0d seen %0d", \
	nm, e, g); end end
module programmable_clock_output_tb;
	logic clk = 1'b0, rstn = 1'b0, xtal, pin;
	logic evt = 1'b0, bkp = 1'b0, stp = 1'b0, sec = 1'b0, cadd = 1'b0;
	logic flg = 1'b0, wr = 1'b0, rd = 1'b0;
	logic cskp = 1'b0, skp = 1'b0; // Skip pulses, riding on the add pulses
	logic [1:0] addr = 2'h0;
	logic [15:0] wdat = 16'h0000, rdat;
	int num_errors = 0, n_tests = 0, r, rises, add_left = 0;
	always #25 clk = ~clk;
	// Old-frequency spans and the gap back to crystal keep full length
	pco_clock_out #(.CYC_ON_32K(16'h0010), .CYC_ON_HF(16'h0010),
		.CYC_OFF(16'h0010), .CYC_LOW_TO_HF(16'h0020)) i_dut (.I_CLK(clk),
		.I_RSTN(rstn),
		.I_XTAL_IN(xtal), .I_EVENT_INPUT_PIN(evt), .I_BACKUP_SUPPLY(bkp),
		.I_STOP_BIT(stp), .I_SEC_WRITE(sec), .I_COMP_ADD(cadd),
		.I_COMP_SKIP(cskp), .I_IRQ_CLOCK_OUT_FLAG(flg), .I_ADDR(addr),
		.I_WDATA(wdat), .I_WR(wr), .I_RD(rd), .O_RDATA(rdat),
		.O_CLOCK_OUT_PIN(pin));
	pco_partner i_far (.i_clk(clk), .i_pin(pin), .o_xtal(xtal),
		.o_rises(rises));
	// Compensation pulses, one every other cycle while requested
	always @(posedge clk) begin
		cadd <= add_left > 0 && !cadd;
		cskp <= add_left > 0 && !cadd && skp;
		if (add_left > 0 && !cadd) add_left <= add_left - 1;
	end
	// Edge counts may be off by one at the window borders
	function automatic int near(int g, int e);
		return (g >= e - 1 && g <= e + 1) ? e : g;
	endfunction : near
	task automatic cyc(int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	task automatic wr_reg(logic [1:0] a, logic [15:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdat <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	// Read data stands only in the cycle after the strobe
	task automatic rd_reg(logic [1:0] a, output logic [15:0] d);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdat;
	endtask : rd_reg
	task automatic meas(int n, output int c);
		int r0;
		#1 r0 = rises;
		cyc(n);
		#1 c = rises - r0;
	endtask : meas
	task automatic pulse_sec();
		@(posedge clk) sec <= 1'b1;
		@(posedge clk) sec <= 1'b0;
	endtask : pulse_sec
	task automatic t_defaults();
		logic [15:0] d;
		rd_reg(2'h0, d);
		`CHK("cfg", 16'h0000, d)
		rd_reg(2'h1, d);
		`CHK("hfdiv", 16'h0000, d)
		rd_reg(2'h3, d);
		`CHK("unmapped", 16'h0000, d)
		add_left = 40;
		meas(800, r);
		`CHK("edges_32k", 100, near(r, 100))
		$display("done defaults");
	endtask : t_defaults
	task automatic t_xtal();
		wr_reg(2'h0, 16'h0002);
		cyc(20);
		meas(2048, r);
		`CHK("edges_1k", 8, near(r, 8))
		add_left = 96;
		meas(2048, r);
		`CHK("edges_1k_comp", 11, near(r, 11))
		// Each skip lands on an add, so the two cancel out
		skp = 1'b1;
		add_left = 96;
		meas(2048, r);
		`CHK("edges_1k_skip", 8, near(r, 8))
		skp = 1'b0;
		wr_reg(2'h0, 16'h0004);
		meas(8192, r);
		`CHK("edges_64", 2, near(r, 2))
		wr_reg(2'h0, 16'h0006);
		pulse_sec();
		meas(2000, r);
		`CHK("edges_1hz", 0, r)
		$display("done xtal");
	endtask : t_xtal
	// Seconds write, then a synced event, both restart the period
	task automatic t_resync();
		for (int k = 0; k < 2; k++) begin
			wr_reg(2'h0, k ? 16'h0012 : 16'h0002);
			for (int i = 0; i < 600 && pin !== 1'b1; i++) @(posedge clk);
			if (k) evt <= 1'b1;
			else pulse_sec();
			cyc(10);
			evt <= 1'b0;
			#1;
			`CHK("pin_restart", 1'b0, pin)
		end
		$display("done resync");
	endtask : t_resync
	task automatic t_stop();
		@(posedge clk) stp <= 1'b1;
		meas(1000, r);
		`CHK("edges_stopped", 0, r)
		wr_reg(2'h0, 16'h0000);
		cyc(40);
		meas(800, r);
		`CHK("edges_32k_stop", 100, near(r, 100))
		@(posedge clk) stp <= 1'b0;
		$display("done stop");
	endtask : t_stop
	task automatic t_hf();
		wr_reg(2'h1, 16'h00ff);
		// Source bit changed in a write of its own
		wr_reg(2'h0, 16'h0001);
		meas(800, r);
		`CHK("edges_old_xtal", 100, near(r, 100))
		cyc(int'(pco_pkg::CYC_OLD_XTAL) - 794);
		meas(20, r);
		`CHK("edges_to_hf", 0, r)
		cyc(40);
		add_left = 40;
		meas(2000, r);
		`CHK("edges_hf", 210, near(r, 210))
		pulse_sec();
		meas(1000, r);
		`CHK("edges_hf_sec", 105, near(r, 105))
		// Divider changed only while the output is disabled
		wr_reg(2'h0, 16'h0009);
		wr_reg(2'h1, 16'h01ff);
		wr_reg(2'h0, 16'h0001);
		cyc(40);
		meas(2000, r);
		`CHK("edges_hf_511", 419, near(r, 419))
		wr_reg(2'h0, 16'h0000);
		meas(2000, r);
		`CHK("edges_old_hf", 419, near(r, 419))
		cyc(int'(pco_pkg::CYC_OLD_HF) - 1994);
		meas(int'(pco_pkg::CYC_LOW_TO_XTAL) - 16, r);
		`CHK("edges_to_xtal", 0, r)
		cyc(40);
		meas(800, r);
		`CHK("edges_back_32k", 100, near(r, 100))
		$display("done hf");
	endtask : t_hf
	task automatic t_disable();
		wr_reg(2'h0, 16'h0008);
		cyc(26);
		meas(200, r);
		`CHK("edges_off", 0, r)
		@(posedge clk) flg <= 1'b1;
		cyc(30);
		meas(800, r);
		`CHK("edges_flag_on", 100, near(r, 100))
		@(posedge clk) flg <= 1'b0;
		cyc(30);
		meas(200, r);
		`CHK("edges_flag_off", 0, r)
		wr_reg(2'h0, 16'h0002);
		cyc(300);
		wr_reg(2'h0, 16'h000a);
		cyc(300);
		meas(500, r);
		`CHK("edges_1k_off", 0, r)
		wr_reg(2'h0, 16'h0000);
		cyc(40);
		$display("done disable");
	endtask : t_disable
	task automatic t_backup();
		logic [15:0] d;
		@(posedge clk) bkp <= 1'b1;
		cyc(5);
		#1;
		`CHK("pin_backup", 1'b0, pin)
		// Status: on, crystal source, backup seen, pin low
		rd_reg(2'h2, d);
		`CHK("status_backup", 16'h0009, d)
		meas(300, r);
		`CHK("edges_backup", 0, r)
		@(posedge clk) bkp <= 1'b0;
		cyc(10);
		meas(800, r);
		`CHK("edges_restored", 100, near(r, 100))
		$display("done backup");
	endtask : t_backup
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : close_out
	// Watchdog sized well above the expected run of about 56k cycles
	initial begin
		#(80000 * 50);
		num_errors++;
		close_out();
	end
	initial begin
		cyc(8);
		rstn <= 1'b1;
		cyc(40);
		t_defaults();
		t_xtal();
		t_resync();
		t_stop();
		t_hf();
		t_disable();
		t_backup();
		close_out();
	end
endmodule : programmable_clock_output_tb
